// ---- spi_host_consts.svh ----
// timing counts, register offsets and field positions of the serial register port master
// assumes a 50 MHz ref_clk and an Avalon-MM slave with 32-bit data
`ifndef SPI_HOST_CONSTS_SVH
`define SPI_HOST_CONSTS_SVH

`define REF_CLK_HZ         50_000_000
// the device master clock rate that the link clock must never exceed
`define LINK_MAX_HZ        13_824_000
// half period floor in ref_clk cycles, rounded up, and never below three for the sampler
`define HALF_MIN_CALC      ((`REF_CLK_HZ + 2 * `LINK_MAX_HZ - 1) / (2 * `LINK_MAX_HZ))
`define HALF_MIN           8'h03
`define HALF_RESET         8'h04

`define OFS_CTRL           4'h0
`define OFS_REG_ADDR       4'h1
`define OFS_WDATA          4'h2
`define OFS_RDATA          4'h3
`define OFS_STATUS         4'h4
`define OFS_DIVIDER        4'h5

`define CTRL_START         0
`define CTRL_READ          1
`define CTRL_ARCH16        2
`define CTRL_BURST         3
`define CTRL_MON_LOW       4
`define CTRL_BURST_LO      8
`define CTRL_BURST_HI      15

`define STATUS_BUSY        0
`define STATUS_DONE        1

`define BYTE_BITS          12'h008
`define WORD_BITS          12'h010
`define ZERO_BYTE          8'h00
`define ZERO_WORD          32'h0000_0000

`endif

// ---- spi_host_pkg.sv ----
// types shared by the serial register port master
// assumes spi_host_consts.svh is included by the design file
package spi_host_pkg;

  typedef enum logic [1:0] {st_idle, st_frame, st_gap} state_type;

  // one access as software ordered it
  typedef struct packed {
    logic       read;
    logic       arch16;
    logic       burst;
    logic       monitor_byte_select;
    logic [7:0] burst_extra;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
  } access_type;

  typedef struct packed {
    logic select_low;
    logic sclk;
    logic serial_in;
  } link_out_type;

endpackage

// ---- spi_host.sv ----
// master for the codec serial register port, ordered by software over Avalon-MM
// assumes serial_out arrives from the device asynchronously; the link clock is made here
//
// Behaviour
// RL1 - every byte and word goes out and comes in most significant bit first
// RL2 - device must resume after the link clock stops; host may pause freely
// RL3 - link clock stays at or below the device master clock rate
// RL4 - 8-bit architecture: device address, register address, then 8 data bits
// RL5 - 16-bit architecture: device address, register address, then 16 data bits
// RL6 - first byte is the device address; top bit 0 writes, 1 reads
// RL7 - device address bit 0 turns burst access on over consecutive registers
// RL8 - device address bit 1 picks upper or lower part of monitoring value
// RL9 - channel select bit 2 is always driven zero
// RL10 - device address bits 3 to 6 are always driven zero
// RL11 - device samples on rising link clock, changes output on falling edges
// RL12 - device output floats while select is high; the model keeps driving serial_out, inverted at each select rise
// RL13 - 8-bit architecture sends three separate select-framed byte transfers
// RL14 - on an 8-bit read the device shifts the register's eight bits out
// RL15 - 16-bit architecture sends address pair frame then data frame
// RL16 - on a 16-bit read keep the first byte, drop the low byte
// RL17 - without burst, extra clocks repeat the same register data
// RL18 - select changing off a multiple of eight clocks soft-resets the device
// RL19 - burst increments the register address after each byte, wrapping to zero
// RL20 - second monitoring read returns value bits 3 to 0 in upper nibble
// RL21 - device ignores a command with any of address bits 6 to 3 set
// RL22 - device keeps decoded addresses across frames for the data frame
`include "spi_host_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_host (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest,
  output var  spi_host_pkg::link_out_type link_out,
  input  wire logic                 serial_out
);
  import spi_host_pkg::*;

  state_type   state;
  access_type  cfg;
  logic [7:0]  half_cycles;
  logic [7:0]  div_cnt;
  logic        tick;
  logic        busy;
  logic        done;
  logic [7:0]  rdata;
  logic [7:0]  rx_shift;
  logic [15:0] tx;
  logic [11:0] bit_cnt;
  logic [1:0]  frame_idx;
  logic [1:0]  last_frame;
  logic [11:0] frame_len;
  logic        data_frame;
  logic        go;
  logic        access_ok;
  logic        sync_meta;
  logic        sync_out;
  logic [11:0] next_bit_cnt;
  logic        capture;
  logic        reload;
  logic [7:0]  dev_addr;
  logic        line_select_low;
  logic        line_sclk;

  // avalon slave: one wait cycle for every access, so answers come on the second edge
  assign access_ok = (avs_read | avs_write) & ~avs_waitrequest;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= `ZERO_WORD;
    end else if (avs_read & avs_waitrequest) begin
      case (avs_address)
        `OFS_CTRL: begin
          avs_readdata <= {16'h0000, cfg.burst_extra, 3'b000, cfg.monitor_byte_select,
                           cfg.burst, cfg.arch16, cfg.read, 1'b0};
        end
        `OFS_REG_ADDR: avs_readdata <= {24'h00_0000, cfg.reg_addr};
        `OFS_WDATA:    avs_readdata <= {24'h00_0000, cfg.wdata};
        `OFS_RDATA:    avs_readdata <= {24'h00_0000, rdata};
        `OFS_STATUS:   avs_readdata <= {30'h0000_0000, done, busy};
        `OFS_DIVIDER:  avs_readdata <= {24'h00_0000, half_cycles};
        default:       avs_readdata <= `ZERO_WORD;
      endcase
    end
  end

  // settings are frozen while a transfer runs so frames stay consistent
  assign go = access_ok & avs_write & (avs_address == `OFS_CTRL)
              & avs_writedata[`CTRL_START] & ~busy;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg         <= '0;
      half_cycles <= `HALF_RESET;
    end else if (access_ok & avs_write & ~busy) begin
      case (avs_address)
        `OFS_CTRL: begin
          cfg.read                <= avs_writedata[`CTRL_READ];
          cfg.arch16              <= avs_writedata[`CTRL_ARCH16];
          cfg.burst               <= avs_writedata[`CTRL_BURST];
          cfg.monitor_byte_select <= avs_writedata[`CTRL_MON_LOW];
          cfg.burst_extra         <= avs_writedata[`CTRL_BURST_HI:`CTRL_BURST_LO];
        end
        `OFS_REG_ADDR: cfg.reg_addr <= avs_writedata[7:0];
        `OFS_WDATA:    cfg.wdata <= avs_writedata[7:0];
        // RL3 clock ceiling
        `OFS_DIVIDER: begin
          half_cycles <= (avs_writedata[7:0] < `HALF_MIN) ? `HALF_MIN : avs_writedata[7:0];
        end
        default: half_cycles <= half_cycles;
      endcase
    end
  end

  // serial_out crosses in through two flops; only the second is read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_meta <= 1'b1;
      sync_out  <= 1'b1;
    end else begin
      sync_meta <= serial_out;
      sync_out  <= sync_meta;
    end
  end

  // half period divider: tick marks each link clock edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 8'h00;
    end else if (state == st_idle || div_cnt == half_cycles - 8'h01) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign tick = (state != st_idle) && (div_cnt == half_cycles - 8'h01);

  // RL6 command byte
  // RL9 channel zero
  // RL10 reserved zero
  // built from the start write itself: cfg only takes these bits on that same edge
  assign dev_addr = {avs_writedata[`CTRL_READ], 4'b0000, 1'b0,
                     avs_writedata[`CTRL_MON_LOW], avs_writedata[`CTRL_BURST]};

  // RL4 8-bit frames
  // RL5 16-bit frames
  // RL7 burst length
  always_comb begin
    last_frame = cfg.arch16 ? 2'd1 : 2'd2;
    data_frame = (frame_idx == last_frame);
    frame_len  = cfg.arch16 ? `WORD_BITS : `BYTE_BITS;
    if (data_frame && cfg.burst) begin
      frame_len = frame_len + {1'b0, cfg.burst_extra, 3'b000};
    end
  end

  assign next_bit_cnt = bit_cnt + 12'h001;
  // RL16 keep first byte
  assign capture = data_frame && (next_bit_cnt[2:0] == 3'b000)
                   && !(cfg.arch16 && next_bit_cnt == `WORD_BITS);
  assign reload  = data_frame && (bit_cnt[2:0] == 3'b000) && (bit_cnt != 12'h000)
                   && !(cfg.arch16 && bit_cnt == `BYTE_BITS);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= st_idle;
      frame_idx <= 2'd0;
      bit_cnt   <= 12'h000;
      busy      <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (go) begin
            state     <= st_frame;
            frame_idx <= 2'd0;
            bit_cnt   <= 12'h000;
            busy      <= 1'b1;
          end
        end
        st_frame: begin
          if (tick && link_out.sclk && bit_cnt == frame_len) begin
            state <= st_gap;
          end else if (tick && !link_out.sclk) begin
            bit_cnt <= next_bit_cnt;
          end
        end
        // RL13 separate frames
        // RL15 two word frames
        st_gap: begin
          if (tick) begin
            bit_cnt <= 12'h000;
            if (frame_idx == last_frame) begin
              state <= st_idle;
              busy  <= 1'b0;
            end else begin
              state     <= st_frame;
              frame_idx <= frame_idx + 2'd1;
            end
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // RL11 change on fall
  // RL18 whole bytes only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_select_low <= 1'b1;
      line_sclk       <= 1'b1;
    end else if (go || (state == st_gap && tick && frame_idx != last_frame)) begin
      line_select_low <= 1'b0;
    end else if (state == st_frame && tick) begin
      if (link_out.sclk && bit_cnt == frame_len) begin
        line_select_low <= 1'b1;
      end else begin
        line_sclk <= ~line_sclk;
      end
    end
  end

  // RL1 msb first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx <= 16'h0000;
    end else if (go) begin
      // frame 0 of 16-bit mode carries both address bytes; 8-bit mode sends only the top one
      tx <= {dev_addr, cfg.reg_addr};
    end else if (state == st_gap && tick && frame_idx != last_frame) begin
      if (cfg.arch16 || frame_idx == 2'd1) begin
        tx <= {cfg.wdata, 8'h00};
      end else begin
        tx <= {cfg.reg_addr, 8'h00};
      end
    end else if (state == st_frame && tick && link_out.sclk && bit_cnt != frame_len
                 && bit_cnt != 12'h000) begin
      if (reload) begin
        tx <= {cfg.wdata, 8'h00};
      end else begin
        tx <= {tx[14:0], 1'b0};
      end
    end
  end

  // one process drives the whole carrier; every field is a flop bit
  always_comb begin
    link_out.select_low = line_select_low;
    link_out.sclk       = line_sclk;
    link_out.serial_in  = tx[15];
  end

  // done stays up until the next start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else if (state == st_gap && tick && frame_idx == last_frame) begin
      done <= 1'b1;
    end else if (go) begin
      done <= 1'b0;
    end
  end

  // sampled at the rising link clock; the sync delay is covered by the half period floor
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_shift <= `ZERO_BYTE;
      rdata    <= `ZERO_BYTE;
    end else if (state == st_frame && tick && !link_out.sclk) begin
      rx_shift <= {rx_shift[6:0], sync_out};
      if (capture && cfg.read) begin
        rdata <= {rx_shift[6:0], sync_out};
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_idle_link_quiet: assert property (state == st_idle |-> link_out.select_low && link_out.sclk)
    else $error("link not idle high outside a transfer");
  a_gap_select_high: assert property (state == st_gap |-> link_out.select_low) // RL13
    else $error("select low between frames");
  a_select_aligned: assert property ($rose(link_out.select_low) |-> bit_cnt[2:0] == 3'b000) // RL18
    else $error("select rose off a byte boundary");
  a_command_zeros: assert property (go |=> tx[14:10] == 5'b00000 && tx[15] == cfg.read) // RL10
    else $error("command byte reserved or channel bits not zero");
  a_change_on_fall: assert property ($changed(link_out.serial_in) && !$fell(link_out.select_low)
                                     |-> $fell(link_out.sclk)) // RL11
    else $error("serial_in moved off a falling link clock");
  a_clock_low_time: assert property ($rose(link_out.sclk) |->
                                     $past(link_out.sclk, 3) == 1'b0) // RL3
    else $error("link clock low phase under three cycles");
  a_shift_msb_first: assert property (state == st_frame && tick && link_out.sclk && !reload
                                      && bit_cnt != 12'h000 && bit_cnt != frame_len
                                      |=> link_out.serial_in == $past(tx[14])) // RL1
    else $error("bits not sent msb first");
  a_word_low_drop: assert property (state == st_frame && cfg.arch16 && cfg.read
                                    && next_bit_cnt == `WORD_BITS && tick && !link_out.sclk
                                    |=> $stable(rdata)) // RL16
    else $error("low byte of a 16-bit read was kept");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer later than one wait cycle");
  a_burst_length: assert property ($rose(link_out.select_low) && state == st_gap
                                   |-> bit_cnt == frame_len) // RL7
    else $error("frame ended before its length");
  a_frame_count: assert property ($fell(busy) |-> frame_idx == (cfg.arch16 ? 2'd1 : 2'd2)) // RL13
    else $error("access ended after the wrong number of frames");
  a_frame_order: assert property (state == st_gap && tick && frame_idx == 2'd0
                                  |=> tx[15:8] == (cfg.arch16 ? cfg.wdata : cfg.reg_addr)) // RL4
    else $error("second frame does not carry the expected byte");
  a_wide_pad_zero: assert property (state == st_frame && data_frame && cfg.arch16
                                    && !link_out.sclk && bit_cnt >= 12'h008
                                    && bit_cnt < 12'h010 |-> !link_out.serial_in) // RL5
    else $error("low byte of a 16-bit data word not sent as zero");
  a_wait_idle_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  c_write8: cover property (go && !cfg.arch16 ##[1:1000] $fell(busy));
  c_read16: cover property (state == st_frame && cfg.arch16 && cfg.read && capture);
  c_burst: cover property (state == st_frame && cfg.burst && reload);
  c_mon_low: cover property (go ##1 tx[9]);
  c_wide_write: cover property (go ##1 cfg.arch16 && !cfg.read);

endmodule

`default_nettype wire

// ---- codec_port_model.sv ----
// behavioural model of the codec serial register port, the device side of the link
// assumes select_low, sclk and serial_in come from spi_host; no clock of its own
`timescale 1ns/1ps
`default_nettype none
module codec_port_model #(
  parameter logic [7:0]  MON_ADDR = 8'hF0,
  parameter logic [11:0] MON_VAL  = 12'hABC
) (
  input  wire logic select_low,
  input  wire logic sclk,
  input  wire logic serial_in,
  output var  logic serial_out
);
  logic [7:0] mem [256];
  logic [7:0] sh, cmd, addr, d;
  logic       bad_cmd;
  int         bits, nbytes;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    {sh, cmd, addr, bits, nbytes, bad_cmd, serial_out} = '0;
  end

  function automatic logic [7:0] rd(input logic [7:0] a);
    rd = (a == MON_ADDR) ? (cmd[1] ? {MON_VAL[3:0], 4'h0} : MON_VAL[11:4]) : mem[a];
  endfunction

  always @(negedge select_low) bits = 0;

  always @(posedge sclk) if (!select_low) begin
    sh = {sh[6:0], serial_in};
    bits++;
    if (bits % 8 == 0) begin
      if (nbytes == 0) cmd = sh;
      else if (nbytes == 1) addr = sh;
      else if (!cmd[7] && cmd[6:3] == 4'h0 && (cmd[0] || nbytes == 2))
        mem[addr + 8'(nbytes - 2)] = sh;
      if (nbytes == 0 && sh[6:2] != 5'h0) bad_cmd = 1'b1;
      nbytes++;
    end
  end

  always @(negedge sclk) if (!select_low && nbytes >= 2 && cmd[7] && cmd[6:3] == 4'h0) begin
    d = rd(addr + (cmd[0] ? 8'(nbytes - 2) : 8'h00));
    serial_out = d[7 - bits % 8];
  end

  always @(posedge select_low) begin
    serial_out = ~serial_out;
    if (bits % 8 != 0 || nbytes >= 3) nbytes = 0;
  end
endmodule
`default_nettype wire

// ---- codec_spi_register_port_test.sv ----
// self-checking bench for spi_host driving the codec port model
// assumes spi_host_pkg is compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
`include "spi_host_consts.svh"
module codec_spi_register_port_test;
  import spi_host_pkg::*;
  logic         ref_clk       = 1'b0;
  logic         rst           = 1'b1;
  logic         avs_read      = 1'b0;
  logic         avs_write     = 1'b0;
  logic [3:0]   avs_address   = 4'h0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata, q;
  logic         avs_waitrequest, serial_out;
  logic         last_sclk     = 1'b1;
  link_out_type link_out;
  int           fails = 0;
  int           checks_done = 0;
  int           run = 0;
  int           min_half = 99;

  always #10 ref_clk = ~ref_clk;

  spi_host DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_out(link_out), .serial_out(serial_out));
  codec_port_model dev (.select_low(link_out.select_low), .sclk(link_out.sclk),
    .serial_in(link_out.serial_in), .serial_out(serial_out));

  // shortest link clock half period, in ref_clk cycles
  always @(posedge ref_clk) begin
    if (!rst && link_out.sclk !== last_sclk) begin
      if (run < min_half) min_half = run;
      run = 1;
    end else run++;
    if (!rst) last_sclk = link_out.sclk;
  end

  task automatic chk(input string what, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) fails++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic fin;
    int n;
    n = 0;
    do begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (q[`STATUS_DONE] !== 1'b1 && n < 999);
    if (n >= 999) fails++;
    bus(1'b0, `OFS_RDATA, 32'h0);
  endtask

  task automatic go(input logic [15:0] ctrl, input logic [7:0] ra, wd);
    bus(1'b1, `OFS_REG_ADDR, {24'h0, ra});
    bus(1'b1, `OFS_WDATA, {24'h0, wd});
    bus(1'b1, `OFS_CTRL, {16'h0, ctrl | 16'h0001});
    fin;
  endtask

  task automatic t_reset;
    chk("idle link", 8'h06, {5'h0, link_out});
    chk("idle wait", 8'h01, {7'h0, avs_waitrequest});
    bus(1'b0, `OFS_DIVIDER, 32'h0);
    chk("divider reset", 8'h04, q[7:0]);
    bus(1'b0, 4'hF, 32'h0);
    chk("unmapped read", 8'h00, q[7:0]);
  endtask

  task automatic t_narrow;
    go(16'h0000, 8'h3C, 8'hA5);
    chk("write 3c", 8'hA5, dev.mem[8'h3C]);
    go(16'h0002, 8'h81, 8'h00);
    chk("read 81", 8'h8A, q[7:0]);
    go(16'h0002, 8'h3C, 8'h00);
    chk("read 3c", 8'hA5, q[7:0]);
  endtask

  task automatic t_wide;
    go(16'h0004, 8'h10, 8'h5A);
    chk("wide write", 8'h5A, dev.mem[8'h10]);
    go(16'h0006, 8'h10, 8'h00);
    chk("wide read", 8'h5A, q[7:0]);
  endtask

  task automatic t_burst;
    go(16'h0208, 8'hFF, 8'hC3);
    chk("burst ff", 8'hC3, dev.mem[8'hFF]);
    chk("burst wrap", 8'hC3, dev.mem[8'h00]);
    chk("burst 01", 8'hC3, dev.mem[8'h01]);
    chk("burst end", 8'h11, dev.mem[8'h02]);
    go(16'h010A, 8'hFE, 8'h00);
    chk("burst read", 8'hC3, q[7:0]);
  endtask

  task automatic t_monitor;
    go(16'h0002, 8'hF0, 8'h00);
    chk("monitor high", 8'hAB, q[7:0]);
    go(16'h0012, 8'hF0, 8'h00);
    chk("monitor low", 8'hC0, q[7:0]);
  endtask

  task automatic t_busy;
    bus(1'b1, `OFS_DIVIDER, 32'h1);
    bus(1'b0, `OFS_DIVIDER, 32'h0);
    chk("divider floor", 8'h03, q[7:0]);
    bus(1'b1, `OFS_REG_ADDR, 32'h3C);
    bus(1'b1, `OFS_CTRL, 32'h3);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("status busy", 8'h01, {6'h0, q[1:0]});
    bus(1'b1, `OFS_REG_ADDR, 32'h55);
    bus(1'b0, `OFS_REG_ADDR, 32'h0);
    chk("write while busy", 8'h3C, q[7:0]);
    fin;
    chk("fast read", 8'hA5, q[7:0]);
    chk("min half", 8'h03, 8'(min_half));
    chk("command zeros", 8'h00, {7'h0, dev.bad_cmd});
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl readback", 8'h02, q[7:0]);
  endtask

  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_narrow;
    t_wide;
    t_burst;
    t_monitor;
    t_busy;
    summarize;
  end

  initial begin
    #1_000_000;
    fails++;
    summarize;
  end
endmodule
`default_nettype wire
